// *** wcm_host.sv ***
module wcm_host (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [4:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [4:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic irq_out,
  wcm_link_if.ctrl link
);
  typedef enum logic {
    WCM_IDLE = 1'b0,
    WCM_SEND = 1'b1
  } wcm_state_t;

  wcm_state_t state;
  logic [3:0] beat;
  logic [4:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [1:0] width;
  logic column_addr_bit_two;
  logic mask_en;
  logic [63:0] data;
  logic [7:0] mask;
  logic [wcm_pkg::STAT_W-1:0] status;
  logic [wcm_pkg::STAT_W-1:0] irq_mask;
  logic [wcm_pkg::STAT_W-1:0] events;
  logic start_req;
  logic [7:0] crc_lo;
  logic [7:0] crc_hi;
  logic narrow;
  logic [15:0] next_dq;
  logic [1:0] next_mask;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [4:0] a);
    return a == wcm_pkg::REG_CTRL || a == wcm_pkg::REG_DATA_LO ||
        a == wcm_pkg::REG_DATA_HI || a == wcm_pkg::REG_MASK ||
        a == wcm_pkg::REG_STATUS || a == wcm_pkg::REG_IRQ_MASK ||
        a == wcm_pkg::REG_CODE;
  endfunction

  assign do_write = !awready_out && !wready_out && !bvalid_out;
  assign narrow = (width == wcm_pkg::WCM_X4);
  assign start_req = do_write && aw_addr == wcm_pkg::REG_CTRL && w_strb[0] &&
      w_data[wcm_pkg::CTRL_START];

  // Write channel: address and data taken in either order, answer after both
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awready_out <= 1'b1;
      wready_out <= 1'b1;
      bvalid_out <= 1'b0;
      bresp_out <= wcm_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (awvalid_in && awready_out) begin
        awready_out <= 1'b0;
        aw_addr <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        wready_out <= 1'b0;
        w_data <= wdata_in;
        w_strb <= wstrb_in;
      end
      if (do_write) begin
        bvalid_out <= 1'b1;
        bresp_out <= mapped(aw_addr) ? wcm_pkg::RESP_OKAY : wcm_pkg::RESP_SLVERR;
      end else if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
    end
  end

  // Frame set-up is frozen while a frame is on the link
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      width <= wcm_pkg::WCM_X8;
      column_addr_bit_two <= 1'b0;
      mask_en <= 1'b0;
      data <= '0;
      mask <= '0;
      irq_mask <= '0;
    end else if (do_write && state == WCM_IDLE) begin
      case (aw_addr)
        wcm_pkg::REG_CTRL: begin
          if (w_strb[0]) begin
            width <= w_data[wcm_pkg::CTRL_WIDTH_LO +: 2];
            column_addr_bit_two <= w_data[wcm_pkg::CTRL_COLUMN_ADDR_BIT_TWO];
            mask_en <= w_data[wcm_pkg::CTRL_MASK_EN];
          end
        end
        wcm_pkg::REG_DATA_LO: data[31:0] <= merge(data[31:0], w_data, w_strb);
        wcm_pkg::REG_DATA_HI: data[63:32] <= merge(data[63:32], w_data, w_strb);
        wcm_pkg::REG_MASK: begin
          if (w_strb[0]) begin
            mask <= w_data[7:0];
          end
        end
        wcm_pkg::REG_IRQ_MASK: begin
          if (w_strb[0]) begin
            irq_mask <= w_data[wcm_pkg::STAT_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end else if (do_write && aw_addr == wcm_pkg::REG_IRQ_MASK && w_strb[0]) begin
      irq_mask <= w_data[wcm_pkg::STAT_W-1:0];
    end
  end

  // Sticky events: a set in the same cycle as its clear wins
  always_comb begin
    events = '0;
    events[wcm_pkg::ST_DONE] = state == WCM_SEND && beat == wcm_pkg::BEAT_CODE_HI;
    events[wcm_pkg::ST_REFUSED] = start_req && state == WCM_SEND;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status <= '0;
    end else if (do_write && aw_addr == wcm_pkg::REG_STATUS && w_strb[0]) begin
      status <= (status & ~w_data[wcm_pkg::STAT_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & irq_mask);
    end
  end

  // Read channel
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out <= '0;
      rresp_out <= wcm_pkg::RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b1;
      rresp_out <= mapped(araddr_in) ? wcm_pkg::RESP_OKAY : wcm_pkg::RESP_SLVERR;
      case (araddr_in)
        wcm_pkg::REG_CTRL: rdata_out <= 32'({mask_en, column_addr_bit_two, width, 1'b0});
        wcm_pkg::REG_DATA_LO: rdata_out <= data[31:0];
        wcm_pkg::REG_DATA_HI: rdata_out <= data[63:32];
        wcm_pkg::REG_MASK: rdata_out <= 32'(mask);
        wcm_pkg::REG_STATUS: rdata_out <= 32'(status);
        wcm_pkg::REG_IRQ_MASK: rdata_out <= 32'(irq_mask);
        wcm_pkg::REG_CODE: rdata_out <= 32'({crc_hi, crc_lo});
        default: rdata_out <= '0;
      endcase
    end else if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
      arready_out <= 1'b1;
    end
  end

  wcm_tree u_tree_lo (
    .lanes_in(data[31:0]),
    .mask_in(mask[3:0]),
    .column_addr_bit_two_in(column_addr_bit_two),
    .mask_used_in(mask_en && !narrow),
    .narrow_in(narrow),
    .crc_out(crc_lo)
  );

  wcm_tree u_tree_hi (
    .lanes_in(data[63:32]),
    .mask_in(mask[7:4]),
    .column_addr_bit_two_in(column_addr_bit_two),
    .mask_used_in(mask_en && !narrow),
    .narrow_in(1'b0),
    .crc_out(crc_hi)
  );

  // Beat contents; idle lanes and filler beats are driven high
  always_comb begin
    next_dq = '1;
    next_mask = '1;
    if (beat <= wcm_pkg::BEAT_DATA_LAST) begin
      for (int l = 0; l < wcm_pkg::LANES; l++) begin
        if (width == wcm_pkg::WCM_X16 || (width == wcm_pkg::WCM_X8 && l < 8) ||
            l < wcm_pkg::NARROW_LANES) begin
          next_dq[l] = data[wcm_pkg::DATA_BEATS*l + int'(beat)];
        end
      end
      if (!narrow) begin
        next_mask[0] = mask[int'(beat)];
      end
      if (width == wcm_pkg::WCM_X16) begin
        next_mask[1] = mask[wcm_pkg::DATA_BEATS + int'(beat)];
      end
    end else if (beat == wcm_pkg::BEAT_CODE_LO) begin
      case (width)
        wcm_pkg::WCM_X4: next_dq[3:0] = crc_lo[3:0];
        wcm_pkg::WCM_X8: next_dq[7:0] = crc_lo;
        wcm_pkg::WCM_X16: next_dq = {crc_hi, crc_lo};
        default: next_dq = '1;
      endcase
    end else if (beat == wcm_pkg::BEAT_CODE_HI && narrow) begin
      next_dq[3:0] = crc_lo[7:4];
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= WCM_IDLE;
      beat <= wcm_pkg::BEAT_FIRST;
    end else begin
      case (state)
        WCM_IDLE: begin
          if (start_req) begin
            state <= WCM_SEND;
            beat <= wcm_pkg::BEAT_FIRST;
          end
        end
        WCM_SEND: begin
          if (beat == wcm_pkg::BEAT_CODE_HI) begin
            state <= WCM_IDLE;
          end
          beat <= beat + 4'h1;
        end
        default: state <= WCM_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link.valid <= 1'b0;
      link.column_addr_bit_two <= 1'b0;
      link.dq <= '1;
      link.mask <= '1;
    end else begin
      link.valid <= state == WCM_SEND;
      link.column_addr_bit_two <= column_addr_bit_two;
      link.dq <= (state == WCM_SEND) ? next_dq : '1;
      link.mask <= (state == WCM_SEND) ? next_mask : '1;
    end
  end
endmodule

// *** wcm_pkg.sv ***
package wcm_pkg;
  typedef enum logic [1:0] {
    WCM_X4 = 2'b00,
    WCM_X8 = 2'b01,
    WCM_X16 = 2'b10
  } wcm_width_t;

  localparam int LANES = 16;
  localparam int TREE_LANES = 8;
  localparam int NARROW_LANES = 4;
  localparam int DATA_BEATS = 4;
  localparam int TREE_W = 72;
  localparam int LANE_STEP = 8;
  localparam int NIBBLE_OFS = 4;
  localparam int MASK_BASE = 64;
  localparam logic [3:0] BEAT_FIRST = 4'h0;
  localparam logic [3:0] BEAT_DATA_LAST = 4'h3;
  localparam logic [3:0] BEAT_CODE_LO = 4'h8;
  localparam logic [3:0] BEAT_CODE_HI = 4'h9;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Host register map, byte addresses
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_DATA_LO = 5'h04;
  localparam logic [4:0] REG_DATA_HI = 5'h08;
  localparam logic [4:0] REG_MASK = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_IRQ_MASK = 5'h14;
  localparam logic [4:0] REG_CODE = 5'h18;
  localparam int CTRL_START = 0;
  localparam int CTRL_WIDTH_LO = 1;
  localparam int CTRL_COLUMN_ADDR_BIT_TWO = 3;
  localparam int CTRL_MASK_EN = 4;
  localparam int ST_DONE = 0;
  localparam int ST_REFUSED = 1;
  localparam int STAT_W = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Lane bits arrive as [4*lane + beat]; unused tree inputs are ones
  function automatic logic [TREE_W-1:0] tree_map(input logic [31:0] lanes,
      input logic [3:0] mask, input logic column_addr_bit_two, input logic mask_used,
      input logic narrow);
    logic [TREE_W-1:0] d;
    int ofs;
    d = '1;
    ofs = column_addr_bit_two ? NIBBLE_OFS : 0;
    for (int n = 0; n < TREE_LANES; n++) begin
      if (!narrow || n < NARROW_LANES) begin
        for (int b = 0; b < DATA_BEATS; b++) begin
          d[LANE_STEP*n + ofs + b] = lanes[DATA_BEATS*n + b];
        end
      end
    end
    if (mask_used && !narrow) begin
      for (int b = 0; b < DATA_BEATS; b++) begin
        d[MASK_BASE + ofs + b] = mask[b];
      end
    end
    return d;
  endfunction

  function automatic logic [7:0] crc8(input logic [TREE_W-1:0] d);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = TREE_W - 1; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
endpackage

// *** wcm_link_if.sv ***
interface wcm_link_if;
  logic valid;
  logic column_addr_bit_two;
  logic [15:0] dq;
  logic [1:0] mask;
  modport ctrl (output valid, output column_addr_bit_two, output dq, output mask);
  modport dev (input valid, input column_addr_bit_two, input dq, input mask);
endinterface

// *** wcm_tree.sv ***
module wcm_tree (
  input wire logic [31:0] lanes_in,
  input wire logic [3:0] mask_in,
  input wire logic column_addr_bit_two_in,
  input wire logic mask_used_in,
  input wire logic narrow_in,
  output logic [7:0] crc_out
);
  always_comb begin
    crc_out = wcm_pkg::crc8(wcm_pkg::tree_map(lanes_in, mask_in, column_addr_bit_two_in,
        mask_used_in, narrow_in));
  end
endmodule

// *** wcm_device.sv ***
module wcm_device (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] width_in,
  input wire logic mask_en_in,
  wcm_link_if.dev link,
  output logic [63:0] data_out,
  output logic [7:0] mask_out,
  output logic column_addr_bit_two_out,
  output logic wr_done_out,
  output logic crc_err_out
);
  logic [3:0] beat;
  logic [15:0] code_beat8;
  logic [3:0] code_beat9;
  logic check;
  logic [7:0] crc_lo;
  logic [7:0] crc_hi;
  logic [15:0] rx_code;
  logic [15:0] diff;
  logic narrow;
  logic mask_used;

  assign narrow = (width_in == wcm_pkg::WCM_X4);
  assign mask_used = mask_en_in && !narrow;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      beat <= wcm_pkg::BEAT_FIRST;
    end else if (link.valid) begin
      beat <= (beat == wcm_pkg::BEAT_CODE_HI) ? wcm_pkg::BEAT_FIRST : beat + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_out <= '0;
      mask_out <= '0;
      column_addr_bit_two_out <= 1'b0;
    end else if (link.valid && beat <= wcm_pkg::BEAT_DATA_LAST) begin
      if (beat == wcm_pkg::BEAT_FIRST) begin
        column_addr_bit_two_out <= link.column_addr_bit_two;
      end
      for (int l = 0; l < wcm_pkg::LANES; l++) begin
        data_out[wcm_pkg::DATA_BEATS*l + int'(beat)] <= link.dq[l];
      end
      for (int k = 0; k < 2; k++) begin
        mask_out[wcm_pkg::DATA_BEATS*k + int'(beat)] <= link.mask[k];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      code_beat8 <= '0;
      code_beat9 <= '0;
    end else if (link.valid && beat == wcm_pkg::BEAT_CODE_LO) begin
      code_beat8 <= link.dq;
    end else if (link.valid && beat == wcm_pkg::BEAT_CODE_HI) begin
      code_beat9 <= link.dq[3:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      check <= 1'b0;
    end else begin
      check <= link.valid && beat == wcm_pkg::BEAT_CODE_HI;
    end
  end

  wcm_tree u_tree_lo (
    .lanes_in(data_out[31:0]),
    .mask_in(mask_out[3:0]),
    .column_addr_bit_two_in(column_addr_bit_two_out),
    .mask_used_in(mask_used),
    .narrow_in(narrow),
    .crc_out(crc_lo)
  );

  wcm_tree u_tree_hi (
    .lanes_in(data_out[63:32]),
    .mask_in(mask_out[7:4]),
    .column_addr_bit_two_in(column_addr_bit_two_out),
    .mask_used_in(mask_used),
    .narrow_in(1'b0),
    .crc_out(crc_hi)
  );

  always_comb begin
    rx_code = code_beat8;
    diff = '0;
    case (width_in)
      wcm_pkg::WCM_X4: begin
        rx_code = {8'h00, code_beat9, code_beat8[3:0]};
        diff = {8'h00, rx_code[7:0] ^ crc_lo};
      end
      wcm_pkg::WCM_X8: begin
        diff = {8'h00, code_beat8[7:0] ^ crc_lo};
      end
      wcm_pkg::WCM_X16: begin
        diff = code_beat8 ^ {crc_hi, crc_lo};
      end
      default: begin
        diff = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_done_out <= 1'b0;
      crc_err_out <= 1'b0;
    end else begin
      wr_done_out <= check;
      crc_err_out <= check && (diff != '0);
    end
  end
endmodule

// *** wcm_checker.sv ***
module wcm_checker (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic valid,
  input wire logic column_addr_bit_two,
  input wire logic [15:0] dq,
  input wire logic [1:0] mask
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;

  // Beat index of the current cycle; ten in the first idle cycle after a frame, zero after that
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 4'h0;
    end else begin
      cnt <= valid ? cnt + 4'h1 : 4'h0;
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  a_ten_beats: assert property (
    $rose(valid) |-> valid [*8] ##1 valid ##1 valid ##1 !valid) else $error("frame length wrong");
  a_gap_after: assert property (
    valid && cnt == 4'h9 |=> !valid) else $error("no idle after frame");
  a_count_cap: assert property (
    valid |-> cnt <= 4'h9) else $error("beat count overrun");
  a_idle_ones: assert property (
    !valid |-> dq == 16'hffff && mask == 2'h3) else $error("idle lines not ones");
  a_pad_ones: assert property (
    valid && cnt >= 4'h4 && cnt <= 4'h7 |-> &dq && &mask) else $error("pad beat not ones");
  a_code_mask: assert property (
    valid && cnt >= 4'h8 |-> mask == 2'h3) else $error("mask lane not ones");
  a_beat9_high: assert property (
    valid && cnt == 4'h9 |-> dq[15:4] == 12'hfff) else $error("beat nine not ones");
  a_addr_bit_holds: assert property (
    valid && cnt != 4'h0 |-> $stable(column_addr_bit_two)) else $error("address bit moved");
endmodule

// *** write_crc_burst_chop_mapper_tb.sv ***
module write_crc_burst_chop_mapper_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, nrst, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv, irq;
  logic men, done, err, done2, err2, col_bit_seen;
  logic [7:0] mout;
  logic [4:0] awa, ara;
  logic [31:0] wd, rd, rdat;
  logic [1:0] br, rr, width, resp;
  logic [63:0] dout;
  logic [15:0] cap [10];
  logic [3:0] cfg [8] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h7, 4'h6, 4'h9, 4'h8};
  int bi, n_mismatch, cmp_count, cyc;
  wcm_link_if lk();
  wcm_link_if lk2();

  wcm_host i_wcm_host (.sys_clk_in(sys_clk), .nrst_in(nrst), .awaddr_in(awa), .awvalid_in(awv),
    .awready_out(awr), .wdata_in(wd), .wstrb_in(4'hf), .wvalid_in(wv), .wready_out(wr),
    .bresp_out(br), .bvalid_out(bv), .bready_in(bready), .araddr_in(ara), .arvalid_in(arv),
    .arready_out(arr), .rdata_out(rd), .rresp_out(rr), .rvalid_out(rv), .rready_in(rready),
    .irq_out(irq), .link(lk.ctrl));
  wcm_device i_wcm_device (.sys_clk_in(sys_clk), .nrst_in(nrst), .width_in(width),
    .mask_en_in(men), .link(lk.dev), .data_out(dout), .mask_out(mout),
    .column_addr_bit_two_out(col_bit_seen),
    .wr_done_out(done), .crc_err_out(err));
  // Second end fed by the bench so that a corrupted code can be sent
  wcm_device i_wcm_device_2 (.sys_clk_in(sys_clk), .nrst_in(nrst), .width_in(2'h1),
    .mask_en_in(1'b0), .link(lk2.dev), .data_out(), .mask_out(), .column_addr_bit_two_out(),
    .wr_done_out(done2), .crc_err_out(err2));
  wcm_checker i_wcm_checker (.sys_clk_in(sys_clk), .nrst_in(nrst), .valid(lk.valid),
    .column_addr_bit_two(lk.column_addr_bit_two), .dq(lk.dq), .mask(lk.mask));

  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (lk.valid) begin
      cap[bi] <= lk.dq;
      bi <= bi + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Independent serial model: unused inputs are ones, bit 71 shifted first
  function automatic logic [7:0] ref_code(input logic [31:0] ln, input logic [3:0] m,
      input logic cb, input logic um, input logic nar);
    logic [71:0] t;
    logic [7:0] c;
    t = '1;
    c = 8'h00;
    for (int i = 0; i < 32; i++)
      if (!nar || i < 16) t[8*(i/4) + 4*cb + i%4] = ln[i];
    for (int i = 0; i < 4; i++)
      if (um) t[64 + 4*cb + i] = m[i];
    for (int i = 71; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ t[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    // This wait ends when bv is seen high, or else at the bench timeout
    do begin
      @(posedge sys_clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = br;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a);
    @(posedge sys_clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rdat = rd;
    resp = rr;
    rready <= 1'b0;
  endtask

  task automatic run_frame(input logic [3:0] c, input logic [63:0] d, input logic [7:0] mk);
    logic [7:0] lo, hi;
    logic [15:0] e;
    logic [63:0] ed;
    logic x4, x16;
    int nl;
    x4 = c[3:2] == wcm_pkg::WCM_X4;
    x16 = c[3:2] == wcm_pkg::WCM_X16;
    nl = x4 ? 4 : x16 ? 16 : 8;
    lo = ref_code(d[31:0], mk[3:0], c[1], c[0] & !x4, x4);
    hi = ref_code(d[63:32], mk[7:4], c[1], c[0], 1'b0);
    for (int i = 0; i < 64; i++)
      ed[i] = (i/4 < nl) ? d[i] : 1'b1;
    wr_reg(wcm_pkg::REG_DATA_LO, d[31:0]);
    wr_reg(wcm_pkg::REG_DATA_HI, d[63:32]);
    wr_reg(wcm_pkg::REG_MASK, {24'h0, mk});
    width <= c[3:2];
    men <= c[0];
    bi = 0;
    wr_reg(wcm_pkg::REG_CTRL, {27'h0, c[0], c[1], c[3:2], 1'b1});
    chk("start resp", resp, wcm_pkg::RESP_OKAY);
    for (int i = 0; i < 40 && done !== 1'b1; i++) @(posedge sys_clk);
    chk("done", done, 1'b1);
    chk("crc_err", err, 1'b0);
    chk("data", dout, ed);
    chk("column bit", col_bit_seen, c[1]);
    chk("mask", mout, {x16 ? mk[7:4] : 4'hf, x4 ? 4'hf : mk[3:0]});
    for (int b = 0; b < 10; b++) begin
      e = '1;
      if (b < 4) for (int l = 0; l < nl; l++) e[l] = d[4*l + b];
      if (b == 8) e = x4 ? {12'hfff, lo[3:0]} : x16 ? {hi, lo} : {8'hff, lo};
      if (b == 9 && x4) e[3:0] = lo[7:4];
      chk("dq", cap[b], e);
    end
    rd_reg(wcm_pkg::REG_CODE);
    chk("code", x16 ? rdat[15:0] : rdat[7:0], x16 ? {hi, lo} : lo);
    rd_reg(wcm_pkg::REG_STATUS);
    chk("status", rdat[1:0], 2'h1);
    chk("irq set", irq, 1'b1);
    wr_reg(wcm_pkg::REG_STATUS, 32'h1);
    @(posedge sys_clk);
    chk("irq clear", irq, 1'b0);
    $display("frame test config %h done", c);
  endtask

  task automatic send2(input logic [31:0] d, input logic [7:0] c, input logic bad);
    logic [15:0] e;
    for (int b = 0; b < 10; b++) begin
      e = '1;
      if (b < 4) for (int l = 0; l < 8; l++) e[l] = d[4*l + b];
      if (b == 8) e[7:0] = c;
      @(posedge sys_clk);
      lk2.valid <= 1'b1;
      lk2.dq <= e;
    end
    @(posedge sys_clk);
    lk2.valid <= 1'b0;
    lk2.dq <= 16'hffff;
    for (int i = 0; i < 10 && done2 !== 1'b1; i++) @(posedge sys_clk);
    chk("far done", done2, 1'b1);
    chk("far crc_err", err2, bad);
  endtask

  initial begin
    {sys_clk, nrst, awv, wv, bready, arv, rready, men, cyc, n_mismatch, cmp_count, bi} = '0;
    {awa, ara, wd, width} = '0;
    lk2.valid = 1'b0;
    lk2.column_addr_bit_two = 1'b0;
    lk2.dq = 16'hffff;
    lk2.mask = 2'h3;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_reg(wcm_pkg::REG_CTRL);
    chk("ctrl reset", rdat, 32'h2);
    rd_reg(wcm_pkg::REG_STATUS);
    chk("status reset", rdat, 32'h0);
    rd_reg(5'h1c);
    chk("unmapped read", {resp, rdat}, {wcm_pkg::RESP_SLVERR, 32'h0});
    wr_reg(5'h1c, 32'hffff_ffff);
    chk("unmapped write", resp, wcm_pkg::RESP_SLVERR);
    $display("register test done");
    wr_reg(wcm_pkg::REG_IRQ_MASK, 32'h1);
    for (int k = 0; k < 8; k++)
      run_frame(cfg[k], 64'hf0e1_d2c3_b4a5_9687 ^ (64'h3c5a_7e19_d24b_86f1 * k),
          8'h5a ^ (8'h37 * k));
    // Masked interrupt first, then unmask the refused-start bit
    wr_reg(wcm_pkg::REG_IRQ_MASK, 32'h0);
    wr_reg(wcm_pkg::REG_CTRL, 32'h3);
    wr_reg(wcm_pkg::REG_CTRL, 32'h3);
    repeat (15) @(posedge sys_clk);
    rd_reg(wcm_pkg::REG_STATUS);
    chk("status refused", rdat[1:0], 2'h3);
    chk("irq masked", irq, 1'b0);
    wr_reg(wcm_pkg::REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk("irq unmasked", irq, 1'b1);
    wr_reg(wcm_pkg::REG_STATUS, 32'h3);
    @(posedge sys_clk);
    chk("irq cleared", irq, 1'b0);
    $display("interrupt test done");
    send2(32'h1234_abcd, ref_code(32'h1234_abcd, 4'h0, 1'b0, 1'b0, 1'b0), 1'b0);
    send2(32'h1234_abcd, ref_code(32'h1234_abcd, 4'h0, 1'b0, 1'b0, 1'b0) ^ 8'h10, 1'b1);
    $display("code error test done");
    end_sim();
  end
endmodule
